// ---- dv/tpcs_bus_master.sv ----
// Two-wire bus master model: makes the serial clock, pulls data low
module tpcs_bus_master (
  // Pacing clock
  input  wire logic ref_clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic smp;  // Line level seen with clock high
  logic odd;  // Alternates the high phase so a bit averages 125 ns

  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    odd = 1'b0;
    smp = 1'b1;
  end

  // Wait whole cycles, moving only at falling edges
  task automatic tk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One clock pulse; data moves only with the clock low
  task automatic bit_io(input logic b);
    scl = 1'b0;
    tk(3);
    sda_low = !b;
    tk(3);
    scl = 1'b1;
    tk(3);
    smp = sda_line;
    tk(3 + odd);
    odd = !odd;
  endtask

  // Data edge during clock high: start is 1 to 0, stop 0 to 1
  task automatic edge_ev(input logic first, input logic second);
    scl = 1'b0;
    tk(3);
    sda_low = !first;
    tk(3);
    scl = 1'b1;
    tk(6);
    sda_low = !second;
    tk(6);
  endtask

  // Byte out MSB first, then release for the ninth clock
  task automatic wbyte(input logic [7:0] v, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i]);
    bit_io(1'b1);
    ak = !smp;
  endtask

  // Byte in; a no-acknowledge ends the read
  task automatic rbyte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      v[i] = smp;
    end
    bit_io(1'b1);
  endtask

  // Kind: 0 two bytes, 1 write data, 2 read data, 3 stepping, 4 address only
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                      input int kind, output logic [7:0] rd, output logic [2:0] ak);
    ak = 3'h0;
    rd = 8'h00;
    edge_ev(1'b1, 1'b0);
    wbyte(a, ak[2]);
    if (kind != 4) wbyte(c, ak[1]);
    if (kind == 1) wbyte(d, ak[0]);
    if (kind == 2) rbyte(rd);
    if (kind != 3) edge_ev(1'b0, 1'b1);
  endtask
endmodule

// ---- dv/tpcs_slave_monitor.sv ----
// Concurrent checks on the slave's pins
module tpcs_slave_monitor
  import tpcs_pkg::*;
#(
  parameter int NV_WRITE_CYC = 500000
)(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         resetn,
  // Two-wire bus pins
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  // Address pins
  input wire logic [3:0]   device_address_pins,
  // Taps and status
  input wire logic [255:0] tap_switches,
  input wire logic         nv_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  int busy_cnt_reg;  // Cycles the write has run so far

  // Count busy cycles; cleared when idle
  always_ff @(posedge ref_clk) begin
    if (!resetn || !nv_busy) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 1;
    end
  end

  // Acknowledge or data low held for at least eight clock cycles
  sequence ack_hold_s;
    sda_oe [*8];
  endsequence
  // Bus quiet after a stop: both lines high
  sequence stop_idle_s;
    scl_in && sda_in;
  endsequence

  a_drive_low_only: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_ack_holds: assert property ($rose(sda_oe) |-> ack_hold_s)
    else $error("data drive too short");
  a_change_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_busy_silent: assert property (nv_busy |-> !sda_oe)
    else $error("acknowledge during write");
  a_busy_from_stop: assert property ($rose(nv_busy) |-> stop_idle_s)
    else $error("write began without stop");
  a_busy_span: assert property ($fell(nv_busy) |-> busy_cnt_reg >= NV_WRITE_CYC)
    else $error("write ended early");
  a_taps_onehot: assert property ($onehot(tap_switches[63:0]) && $onehot(tap_switches[127:64])
    && $onehot(tap_switches[191:128]) && $onehot(tap_switches[255:192]))
    else $error("tap group not one-hot");
  a_taps_frozen: assert property (nv_busy && $past(nv_busy) |-> $stable(tap_switches))
    else $error("wiper moved during write");
endmodule

bind tpcs_slave tpcs_slave_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_monitor (
  .ref_clk, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe,
  .device_address_pins, .tap_switches, .nv_busy
);

// ---- dv/tpcs_slave_tb.sv ----
// Self-checking bench for the two-wire potentiometer command slave
`include "tpcs_defs.svh"
module tpcs_slave_tb
  import tpcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NV_CYC = 200;  // Shortened write time keeps the run brief
  logic         ref_clk = 1'b0;
  logic         resetn = 1'b0;
  logic [3:0]   pins;
  logic         scl, sda_low, sda_line, sda_out, sda_oe, nv_busy, up;
  logic [255:0] taps;
  logic [7:0]   wiper [4];      // Expected wiper positions
  logic [7:0]   stored [4][4];  // Expected stored settings
  logic [7:0]   rd, d;
  logic [2:0]   ak;
  logic [3:0]   rv;
  int           err_total = 0, total_checks = 0, cycles = 0, seed = 32'hea55;

  // Pull-up wins unless a party pulls low
  assign sda_line = !(sda_low || (sda_oe && !sda_out));

  tpcs_slave #(.NV_WRITE_CYC(NV_CYC)) uut (
    .ref_clk, .resetn, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .device_address_pins(pins), .tap_switches(taps), .nv_busy
  );
  tpcs_bus_master u_mst (.ref_clk, .sda_line, .scl, .sda_low);

  always #5 ref_clk = !ref_clk;

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] ins(logic [3:0] op, logic [1:0] p, logic [1:0] r);
    tpcs_instr_t t;
    t = '{op, p, r};
    return t;
  endfunction

  // Saturating step of the low six bits
  function automatic logic [7:0] step_exp(logic [7:0] w, logic dir);
    if (dir && w[5:0] != 6'h3F) return w + 8'h01;
    if (!dir && w[5:0] != 6'h00) return w - 8'h01;
    return w;
  endfunction

  task automatic cmd(input logic [7:0] c, input logic [7:0] dv, input int kind);
    u_mst.xfer({`TPCS_TYPE_ID, pins}, c, dv, kind, rd, ak);
  endtask

  task automatic tap_chk();
    for (int p = 0; p < 4; p++)
      chk(taps[p*64 +: 64], 64'h1 << wiper[p][5:0]);
  endtask

  // First poll refused while writing, later one answered
  task automatic poll();
    int n;
    cmd(8'h00, 8'h00, 4);
    chk(ak[2], 1'b0);
    for (n = 0; n < 20 && !ak[2]; n++)
      cmd(8'h00, 8'h00, 4);
    chk(ak[2], 1'b1);
    chk(nv_busy, 1'b0);
  endtask

  initial begin
    pins = 4'h0;
    wiper = '{default: 8'h00};
    stored = '{default: '{default: 8'h00}};
    repeat (20) @(negedge ref_clk);
    tap_chk();
    chk(sda_oe, 1'b0);
    chk(nv_busy, 1'b0);
    pins = 4'($random(seed));
    resetn = 1'b1;
    u_mst.tk(5);
    // Address bits with no start first
    u_mst.wbyte({`TPCS_TYPE_ID, pins}, ak[2]);
    chk(ak[2], 1'b0);
    for (int i = 1; i < 16; i++) begin
      u_mst.xfer({`TPCS_TYPE_ID ^ 4'(i), pins}, 8'hA0, 8'h3F, 1, rd, ak);
      chk(ak, 3'h0);
      u_mst.xfer({`TPCS_TYPE_ID, pins ^ 4'(i)}, 8'hA0, 8'h3F, 1, rd, ak);
      chk(ak, 3'h0);
    end
    // Wiper writes and reads, register bits ignored
    for (int p = 0; p < 4; p++) begin
      d = 8'($random(seed));
      wiper[p] = d;
      cmd(ins(`TPCS_OP_WR_WIPER, 2'(p), 2'($random(seed))), d, 1);
      chk(ak, 3'h7);
      cmd(ins(`TPCS_OP_RD_WIPER, 2'(p), 2'(p)), 8'h00, 2);
      chk(rd, d);
    end
    u_mst.tk(102);
    tap_chk();
    // Every stored setting written, each with polling
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      stored[i/4][i%4] = d;
      cmd(ins(`TPCS_OP_WR_STORED, 2'(i/4), 2'(i)), d, 1);
      chk(ak, 3'h7);
      chk(nv_busy, 1'b1);
      poll();
    end
    // Single-pot copies both ways
    for (int p = 0; p < 4; p++) begin
      rv = 4'($random(seed));
      wiper[p] = stored[p][rv[1:0]];
      cmd(ins(`TPCS_OP_CP_TO_WIPER, 2'(p), rv[1:0]), 8'h00, 0);
      chk(ak[2:1], 2'h3);
      u_mst.tk(102);
      tap_chk();
      stored[p][rv[3:2]] = wiper[p];
      cmd(ins(`TPCS_OP_CP_TO_STORE, 2'(p), rv[3:2]), 8'h00, 0);
      chk(ak[2:1], 2'h3);
      poll();
    end
    // Global copies, pot bits ignored
    rv = 4'($random(seed));
    for (int p = 0; p < 4; p++)
      stored[p][rv[1:0]] = wiper[p];
    cmd(ins(`TPCS_OP_GCP_TO_STORE, rv[3:2], rv[1:0]), 8'h00, 0);
    chk(ak[2:1], 2'h3);
    poll();
    rv[1:0] = rv[1:0] + 2'h1;
    for (int p = 0; p < 4; p++)
      wiper[p] = stored[p][rv[1:0]];
    cmd(ins(`TPCS_OP_GCP_TO_WIPER, rv[3:2], rv[1:0]), 8'h00, 0);
    chk(ak[2:1], 2'h3);
    u_mst.tk(102);
    tap_chk();
    // Unused opcode: acknowledged, then no register changes
    cmd(ins(4'h3, rv[3:2], rv[1:0]), 8'h00, 0);
    chk(ak[2:1], 2'h3);
    for (int i = 0; i < 16; i++) begin
      cmd(ins(`TPCS_OP_RD_STORED, 2'(i/4), 2'(i)), 8'h00, 2);
      chk(rd, stored[i/4][i%4]);
    end
    // Stepping: saturate high, random walk, then down to the floor
    wiper[rv[3:2]] = 8'h3C;
    cmd(ins(`TPCS_OP_WR_WIPER, rv[3:2], 2'h0), 8'h3C, 1);
    chk(ak, 3'h7);
    cmd(ins(`TPCS_OP_STEP, rv[3:2], rv[1:0]), 8'h00, 3);
    chk(ak[2:1], 2'h3);
    for (int i = 0; i < 100; i++) begin
      up = (i < 8) ? 1'b1 : (i < 28) ? 1'($random(seed)) : 1'b0;
      u_mst.bit_io(up);
      wiper[rv[3:2]] = step_exp(wiper[rv[3:2]], up);
    end
    u_mst.edge_ev(1'b0, 1'b1);
    // The stop's own high pulse has data low, so it steps down once more
    wiper[rv[3:2]] = step_exp(wiper[rv[3:2]], 1'b0);
    u_mst.tk(102);
    tap_chk();
    cmd(ins(`TPCS_OP_RD_WIPER, rv[3:2], 2'h0), 8'h00, 2);
    chk(rd, wiper[rv[3:2]]);
    stop_test();
  end
endmodule

// ---- verilog/tpcs_defs.svh ----
// Constants for the two-wire potentiometer command slave
// Operation
// - Data changes only while clock low
// - Ignore bus until start condition seen
// - Receiver pulls data low on ninth clock
// - Acknowledge address, command, then data byte
// - Upper address nibble must match type identifier
// - Lower address nibble must match address pins
// - Withhold address acknowledge while write busy
// - Instruction: opcode, pot select, register select
// - Wiper low six bits decoded one-hot
// - Four copy instructions carry no data byte
// - Data-to-wiper copy acts as volatile write
// - Wiper-to-data copy is a nonvolatile write
// - Copy acts on one pot or all
// - Register reads and writes take three bytes
// - Clock pulses step wiper up or down
// - Opcodes for wiper and data reads, writes
// - Opcodes for single-pot copies both ways
// - Global copy opcodes and step-enable opcode
`ifndef TPCS_DEFS_SVH
`define TPCS_DEFS_SVH

// Device type identifier in the address upper nibble (arbitrary value)
`define TPCS_TYPE_ID        4'hA
// Opcodes
`define TPCS_OP_RD_WIPER    4'h9
`define TPCS_OP_WR_WIPER    4'hA
`define TPCS_OP_RD_STORED   4'hB
`define TPCS_OP_WR_STORED   4'hC
`define TPCS_OP_CP_TO_WIPER 4'hD
`define TPCS_OP_CP_TO_STORE 4'hE
`define TPCS_OP_GCP_TO_WIPER 4'h1
`define TPCS_OP_GCP_TO_STORE 4'h8
`define TPCS_OP_STEP        4'h2
// Wiper tap limits
`define TPCS_TAP_MAX        6'h3F
`define TPCS_TAP_MIN        6'h00
// Timing: clock rate and delays
`define TPCS_CLK_MHZ        100
`define TPCS_NV_WRITE_US    5000
`define TPCS_NV_WRITE_CYC   (`TPCS_NV_WRITE_US * `TPCS_CLK_MHZ)
`define TPCS_SETTLE_NS      1000
`define TPCS_SETTLE_CYC     ((`TPCS_SETTLE_NS * `TPCS_CLK_MHZ) / 1000)
// Reset values
`define TPCS_WIPER_RST      8'h00
`define TPCS_STORED_RST     8'h00

`endif

// ---- verilog/tpcs_pkg.sv ----
// Types for the two-wire potentiometer command slave
package tpcs_pkg;
  // Decoded instruction byte
  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] pot;
    logic [1:0] regsel;
  } tpcs_instr_t;

  // Serial engine phases
  typedef enum logic [3:0] {
    TPCS_IDLE, TPCS_ADDR, TPCS_ADDR_ACK, TPCS_INSTR, TPCS_INSTR_ACK,
    TPCS_WDATA, TPCS_WDATA_ACK, TPCS_RDATA, TPCS_RDATA_ACK, TPCS_STEP, TPCS_IGNORE
  } tpcs_state_t;

  // Open-drain data pin
  typedef struct packed {
    logic o;
    logic oe;
  } tpcs_od_t;
endpackage

// ---- verilog/tpcs_slave.sv ----
// Two-wire serial slave and instruction interpreter for four pots
`include "tpcs_defs.svh"
module tpcs_slave
  import tpcs_pkg::*;
#(
  parameter int NV_WRITE_CYC = `TPCS_NV_WRITE_CYC
)(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  // Two-wire bus pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  // Address pins
  input  wire logic [3:0]    device_address_pins,
  // Tap switches, one group per pot
  output logic      [255:0]  tap_switches,
  // Status
  output logic               nv_busy
);
  // Pin synchronisers
  logic [1:0]  scl_sync_reg;     // First stage feeds only second
  logic [1:0]  sda_sync_reg;
  logic [3:0]  addr_sync0_reg;
  logic [3:0]  addr_sync1_reg;
  logic        scl_reg;          // Delayed stable clock
  logic        sda_reg;          // Delayed stable data
  // Bus events
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  // Serial engine
  tpcs_state_t state_reg;
  logic [7:0]  shift_reg;        // Received or sent byte
  logic [3:0]  bit_cnt_reg;      // Bits done in the byte
  tpcs_instr_t instr_reg;        // Latched instruction
  tpcs_od_t    pin_reg;          // Data pin drive
  logic        nv_pending_reg;   // Nonvolatile write awaiting stop
  logic [31:0] nv_cnt_reg;       // Nonvolatile write countdown
  logic        nv_busy_reg;      // Busy flag, mirrors a nonzero countdown
  // Storage: wiper positions and stored settings
  logic [7:0]  wiper_position_register [4];
  logic [7:0]  stored_setting_registers [16];
  logic [7:0]  rd_byte;

  // Two flip-flops on every outside input
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scl_sync_reg   <= 2'h3;
      sda_sync_reg   <= 2'h3;
      addr_sync0_reg <= 4'h0;
      addr_sync1_reg <= 4'h0;
      scl_reg        <= 1'b1;
      sda_reg        <= 1'b1;
    end else begin
      scl_sync_reg   <= {scl_sync_reg[0], scl_in};
      sda_sync_reg   <= {sda_sync_reg[0], sda_in};
      // Address straps pass two stages like the bus pins
      addr_sync0_reg <= device_address_pins;
      addr_sync1_reg <= addr_sync0_reg;
      scl_reg        <= scl_sync_reg[1];
      sda_reg        <= sda_sync_reg[1];
    end
  end

  // Edge and condition detection; data moving under high clock is a condition
  assign scl_rise   = scl_sync_reg[1] && !scl_reg;
  assign scl_fall   = !scl_sync_reg[1] && scl_reg;
  // Conditions need the clock high on both stages, so a late data edge is no condition
  assign start_seen = scl_sync_reg[1] && scl_reg && sda_reg && !sda_sync_reg[1];
  assign stop_seen  = scl_sync_reg[1] && scl_reg && !sda_reg && sda_sync_reg[1];

  // Read data source for the selected register
  always_comb begin
    if (instr_reg.opcode == `TPCS_OP_RD_WIPER) begin
      // Register bits are don't-care for the wiper read
      rd_byte = wiper_position_register[instr_reg.pot];
    end else begin
      rd_byte = stored_setting_registers[{instr_reg.pot, instr_reg.regsel}];
    end
  end

  // Serial engine: bytes, acknowledges and command flow
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg   <= TPCS_IDLE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      instr_reg   <= '0;
      pin_reg     <= '0;
    end else if (stop_seen) begin
      state_reg <= TPCS_IDLE;
      pin_reg   <= '0;
    end else if (start_seen) begin
      // A start is honoured in any state, even mid-byte
      state_reg   <= TPCS_ADDR;
      bit_cnt_reg <= 4'h0;
      pin_reg     <= '0;
    end else begin
      case (state_reg)
        TPCS_ADDR, TPCS_INSTR, TPCS_WDATA: begin
          // Sample on rising clock
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == TPCS_ADDR) begin
              // Silent on mismatch or while writing
              if (shift_reg[7:4] == `TPCS_TYPE_ID
                  && shift_reg[3:0] == addr_sync1_reg
                  && !nv_busy) begin
                pin_reg   <= '{o: 1'b0, oe: 1'b1};
                state_reg <= TPCS_ADDR_ACK;
              end else begin
                state_reg <= TPCS_IGNORE;
              end
            end else if (state_reg == TPCS_INSTR) begin
              instr_reg <= shift_reg;
              pin_reg   <= '{o: 1'b0, oe: 1'b1};
              state_reg <= TPCS_INSTR_ACK;
            end else begin
              pin_reg   <= '{o: 1'b0, oe: 1'b1};
              state_reg <= TPCS_WDATA_ACK;
            end
          end
        end
        TPCS_ADDR_ACK: begin
          // Release at the fall that ends the ninth clock
          if (scl_fall) begin
            pin_reg   <= '0;
            state_reg <= TPCS_INSTR;
          end
        end
        TPCS_INSTR_ACK: begin
          // Next phase chosen by the opcode just latched
          if (scl_fall) begin
            case (instr_reg.opcode)
              `TPCS_OP_RD_WIPER, `TPCS_OP_RD_STORED: begin
                // Device drives first read bit at once
                shift_reg   <= {rd_byte[6:0], 1'b0};
                bit_cnt_reg <= 4'h1;
                pin_reg     <= '{o: 1'b0, oe: !rd_byte[7]};
                state_reg   <= TPCS_RDATA;
              end
              `TPCS_OP_WR_WIPER, `TPCS_OP_WR_STORED: begin
                pin_reg   <= '0;
                state_reg <= TPCS_WDATA;
              end
              `TPCS_OP_STEP: begin
                pin_reg   <= '0;
                state_reg <= TPCS_STEP;
              end
              // Copies and unknown opcodes end after this byte
              default: begin
                pin_reg   <= '0;
                state_reg <= TPCS_IGNORE;
              end
            endcase
          end
        end
        TPCS_WDATA_ACK: begin
          // Data byte taken; nothing more until the stop
          if (scl_fall) begin
            pin_reg   <= '0;
            state_reg <= TPCS_IGNORE;
          end
        end
        TPCS_RDATA: begin
          // Next bit goes out after each fall, MSB first
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              pin_reg   <= '0;
              state_reg <= TPCS_RDATA_ACK;
            end else begin
              pin_reg     <= '{o: 1'b0, oe: !shift_reg[7]};
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        TPCS_RDATA_ACK: begin
          // Acknowledge or not, one byte ends the read
          if (scl_fall) begin
            state_reg <= TPCS_IGNORE;
          end
        end
        TPCS_STEP, TPCS_IGNORE, TPCS_IDLE: begin
          // Pin released; stepping lives in the wiper process
          pin_reg <= '0;
        end
        // Unused encodings fall back to idle
        default: begin
          state_reg <= TPCS_IDLE;
        end
      endcase
    end
  end

  // Wiper registers: direct write, copies and stepping
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int p = 0; p < 4; p++) begin
        wiper_position_register[p] <= `TPCS_WIPER_RST;
      end
    end else if (state_reg == TPCS_WDATA && scl_fall && bit_cnt_reg == 4'h8
                 && instr_reg.opcode == `TPCS_OP_WR_WIPER) begin
      // Direct write lands at the fall after the last data bit
      wiper_position_register[instr_reg.pot] <= shift_reg;
    end else if (state_reg == TPCS_INSTR_ACK && scl_fall) begin
      if (instr_reg.opcode == `TPCS_OP_CP_TO_WIPER) begin
        wiper_position_register[instr_reg.pot] <=
          stored_setting_registers[{instr_reg.pot, instr_reg.regsel}];
      end else if (instr_reg.opcode == `TPCS_OP_GCP_TO_WIPER) begin
        for (int p = 0; p < 4; p++) begin
          wiper_position_register[p] <=
            stored_setting_registers[{2'(p), instr_reg.regsel}];
        end
      end
    end else if (state_reg == TPCS_STEP && scl_rise) begin
      // Step per high pulse; saturate at the array ends
      if (sda_reg && wiper_position_register[instr_reg.pot][5:0] != `TPCS_TAP_MAX) begin
        wiper_position_register[instr_reg.pot][5:0] <=
          wiper_position_register[instr_reg.pot][5:0] + 6'h01;
      end else if (!sda_reg
                   && wiper_position_register[instr_reg.pot][5:0] != `TPCS_TAP_MIN) begin
        wiper_position_register[instr_reg.pot][5:0] <=
          wiper_position_register[instr_reg.pot][5:0] - 6'h01;
      end
    end
  end

  // Stored settings: direct write and copies from wipers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        stored_setting_registers[i] <= `TPCS_STORED_RST;
      end
    end else if (state_reg == TPCS_WDATA && scl_fall && bit_cnt_reg == 4'h8
                 && instr_reg.opcode == `TPCS_OP_WR_STORED) begin
      // Value lands now; the slow write itself begins at the stop
      stored_setting_registers[{instr_reg.pot, instr_reg.regsel}] <= shift_reg;
    end else if (state_reg == TPCS_INSTR_ACK && scl_fall) begin
      if (instr_reg.opcode == `TPCS_OP_CP_TO_STORE) begin
        stored_setting_registers[{instr_reg.pot, instr_reg.regsel}] <=
          wiper_position_register[instr_reg.pot];
      end else if (instr_reg.opcode == `TPCS_OP_GCP_TO_STORE) begin
        for (int p = 0; p < 4; p++) begin
          stored_setting_registers[{2'(p), instr_reg.regsel}] <=
            wiper_position_register[p];
        end
      end
    end
  end

  // Nonvolatile write timing; the write starts at the closing stop
  // Count is a parameter so a bench may shorten the write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nv_pending_reg <= 1'b0;
      nv_cnt_reg     <= 32'h0000_0000;
      nv_busy_reg    <= 1'b0;
    end else begin
      if (state_reg == TPCS_WDATA && scl_fall && bit_cnt_reg == 4'h8
          && instr_reg.opcode == `TPCS_OP_WR_STORED) begin
        nv_pending_reg <= 1'b1;
      end else if (state_reg == TPCS_INSTR_ACK && scl_fall
                   && (instr_reg.opcode == `TPCS_OP_CP_TO_STORE
                       || instr_reg.opcode == `TPCS_OP_GCP_TO_STORE)) begin
        nv_pending_reg <= 1'b1;
      end else if (stop_seen || start_seen) begin
        nv_pending_reg <= 1'b0;   // Cleared at the stop that begins the write, or aborted by a restart
      end
      // Busy drops in the same cycle the count reaches zero
      if (stop_seen && nv_pending_reg) begin
        nv_cnt_reg  <= 32'(NV_WRITE_CYC);
        nv_busy_reg <= (NV_WRITE_CYC != 0);
      end else if (nv_cnt_reg != 32'h0000_0000) begin
        nv_cnt_reg  <= nv_cnt_reg - 32'h0000_0001;
        nv_busy_reg <= (nv_cnt_reg != 32'h0000_0001);
      end
    end
  end

  // Busy leaves from a flip-flop, free of decode glitches
  assign nv_busy = nv_busy_reg;

  // Open drain: only ever pull low
  assign sda_out = pin_reg.o;
  assign sda_oe  = pin_reg.oe;

  // One decoder per pot
  // Each pot settles on its own count, so pots never wait on each other
  for (genvar g = 0; g < 4; g++) begin : g_pot
    tpcs_tap_decode u_dec (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .position (wiper_position_register[g][5:0]),
      .taps     (tap_switches[g*64 +: 64])
    );
  end
endmodule

// ---- verilog/tpcs_tap_decode.sv ----
// One-hot tap switch decoder for one wiper, with a settle delay
`include "tpcs_defs.svh"
module tpcs_tap_decode
  import tpcs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Wiper position in
  input  wire logic [5:0]  position,
  // Tap switches out
  output logic      [63:0] taps
);
  logic [5:0]  shown_reg;   // Position the switches show
  logic [15:0] settle_reg;  // Cycles left before the switches follow

  // Switches follow the register only after the settle time
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shown_reg  <= 6'h00;
      settle_reg <= 16'h0000;
    end else if (position != shown_reg) begin
      if (settle_reg == 16'h0000) begin
        settle_reg <= 16'(`TPCS_SETTLE_CYC);
      end else if (settle_reg == 16'h0001) begin
        shown_reg  <= position;
        settle_reg <= 16'h0000;
      end else begin
        settle_reg <= settle_reg - 16'h0001;
      end
    end else begin
      settle_reg <= 16'h0000;
    end
  end

  // Exactly one switch on, never two, to avoid shorting segments
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      taps <= 64'h0000_0000_0000_0001;
    end else begin
      taps <= 64'h0000_0000_0000_0001 << shown_reg;
    end
  end
endmodule
